// [hw/asr_map.svh]
`ifndef ASR_MAP_SVH
`define ASR_MAP_SVH

// Register byte offsets
`define ASR_OFS_CTRL 5'h00
`define ASR_OFS_STATUS 5'h04
`define ASR_OFS_DATA 5'h08
`define ASR_OFS_DIV 5'h0c
`define ASR_OFS_EVT 5'h10
`define ASR_OFS_EVT_CLR 5'h14
`define ASR_OFS_EVT_ENA 5'h18

// Control fields
`define ASR_CTRL_RX_EN 0
`define ASR_CTRL_NINE 1

// Status fields
`define ASR_STS_NINTH 0
`define ASR_STS_OVR 1
`define ASR_STS_FRAME_ERR 2
`define ASR_STS_READY 3

// Event fields, shared by event status, clear and enable
`define ASR_EVT_WORD 0
`define ASR_EVT_OVR 1
`define ASR_EVT_FRAME_ERR 2
`define ASR_EVT_W 3

// Reset values
`define ASR_CTRL_RST 2'h0
`define ASR_EVT_ENA_RST 3'h0

// Timing
`define ASR_CLK_HZ 125000000
`define ASR_BAUD_DEFAULT 115200
`define ASR_OVERSAMPLE 16
`define ASR_VOTE_FIRST 4'h7
`define ASR_VOTE_LAST 4'h9

`endif

// [hw/asr_pkg.sv]
package asr_pkg;

	typedef enum logic [1:0] {
		ASR_IDLE = 2'b00,
		ASR_DATA = 2'b01,
		ASR_STOP = 2'b10
	} asr_state_t;

	typedef struct packed {
		logic frame_err;
		logic ninth;
		logic [7:0] data;
	} asr_entry_t;

	typedef struct packed {
		logic run;
		logic [15:0] div_cnt;
		logic [3:0] phase;
		logic [1:0] ones;
		logic prev_rx;
		logic bit_stb;
		logic bit_val;
	} asr_front_t;

endpackage

// [hw/asr_front.sv]
`timescale 1ns/1ps
`include "asr_map.svh"

module asr_front (
	input wire logic i_mclk, // System clock
	input wire logic i_rst_n, // Synchronous reset, active low
	input wire logic i_enable, // Start search allowed
	input wire logic i_halt, // Return to idle search
	input wire logic [15:0] i_div, // Clocks per oversample tick
	input wire logic i_rx, // Serial receive pin
	output logic o_bit_stb, // One pulse per bit period
	output logic o_bit // Voted bit value
);
	import asr_pkg::*;

	asr_front_t front_reg;
	asr_front_t front_next;
	logic tick;

	always_comb begin
		front_next = front_reg;
		front_next.bit_stb = 1'b0;
		front_next.prev_rx = i_rx;
		tick = (front_reg.div_cnt >= i_div - 16'h0001);
		if (i_halt) begin
			front_next.run = 1'b0;
		end else if (!front_reg.run) begin
			// Falling edge on the idle-high line opens a frame
			if (i_enable && front_reg.prev_rx && !i_rx) begin
				front_next.run = 1'b1;
				front_next.div_cnt = 16'h0000;
				front_next.phase = 4'h0;
				front_next.ones = 2'h0;
			end
		end else begin
			front_next.div_cnt = tick ? 16'h0000 : front_reg.div_cnt + 16'h0001;
			if (tick) begin
				front_next.phase = front_reg.phase + 4'h1;
				if (front_reg.phase >= `ASR_VOTE_FIRST && front_reg.phase <= `ASR_VOTE_LAST)
					front_next.ones = front_reg.ones + {1'b0, i_rx};
				// Mid-bit vote of three samples rejects single glitches
				if (front_reg.phase == `ASR_VOTE_LAST) begin
					front_next.bit_stb = 1'b1;
					front_next.bit_val = (front_reg.ones + {1'b0, i_rx}) >= 2'h2;
					front_next.ones = 2'h0;
				end
			end
		end
	end

	always_ff @(posedge i_mclk) begin
		if (!i_rst_n) begin
			front_reg <= '{run: 1'b0, div_cnt: 16'h0000, phase: 4'h0, ones: 2'h0,
				prev_rx: 1'b1, bit_stb: 1'b0, bit_val: 1'b1};
		end else begin
			front_reg <= front_next;
		end
	end

	assign o_bit_stb = front_reg.bit_stb;
	assign o_bit = front_reg.bit_val;

endmodule

// [hw/asr_receiver.sv]
// Summary of operation
// - A front end sampling at sixteen times the baud rate feeds a shifter that moves once per bit.
// - After the stop bit the assembled word enters the holding FIFO if it has a free entry and overrun is clear.
// - A stored word sets the ready flag; the interrupt fires only when its enable is set.
// - The ready flag is read-only and drops when reads have emptied the FIFO.
// - The holding FIFO is two deep, so two words wait while a third shifts in.
// - A stop bit seen while the FIFO is full and no data read pops an entry in that cycle sets overrun and loses the shifted word.
// - Overrun clears only when software clears the receive enable bit.
// - While overrun is set no word moves from the shift register into the FIFO.
// - A stop bit sampled low marks that word with a framing error.
// - Each FIFO entry keeps its own framing error and ninth bit beside the data.
// - Each data read exposes the next entry's ninth and framing bits; status is read first.
//
// Decided for this implementation: the Avalon-MM interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`include "asr_map.svh"

module asr_receiver #(
	parameter int DEPTH = 2, // Holding FIFO entries
	parameter int CLK_HZ = `ASR_CLK_HZ, // Clock rate
	parameter int BAUD = `ASR_BAUD_DEFAULT // Baud rate after reset
) (
	input wire logic i_mclk, // System clock
	input wire logic i_rst_n, // Synchronous reset, active low
	input wire logic [4:0] i_address, // Avalon byte address
	input wire logic i_read, // Avalon read
	input wire logic i_write, // Avalon write
	input wire logic [3:0] i_byteenable, // Avalon byte enables
	input wire logic [31:0] i_writedata, // Avalon write data
	output logic [31:0] o_readdata, // Avalon read data
	output logic o_waitrequest, // Avalon wait request
	input wire logic i_serial_receive_pin, // Serial line from the transmitter
	output logic o_irq // Level interrupt
);
	import asr_pkg::*;

	localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int CW = $clog2(DEPTH + 1);
	localparam int DIV_INT = (BAUD > 0) ? CLK_HZ / (`ASR_OVERSAMPLE * BAUD) : 0;
	localparam logic [15:0] DIV_RST = DIV_INT[15:0];
	localparam logic [PW-1:0] LAST_PTR = PW'(DEPTH - 1);
	localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);

	generate
		if (DEPTH < 2) begin : g_depth_check
			$error("asr_receiver: DEPTH must be at least 2");
		end
		if (BAUD < 1 || CLK_HZ < 1) begin : g_rate_check
			$error("asr_receiver: CLK_HZ and BAUD must be positive");
		end
		if (DIV_INT < 2 || DIV_INT > 65535) begin : g_div_check
			$error("asr_receiver: CLK_HZ and BAUD give an unusable divisor");
		end
	endgenerate

	typedef struct packed {
		logic wait_r;
		logic [31:0] rdata;
		logic pop_ok;
		logic irq;
		logic rx_en;
		logic nine;
		logic [15:0] div;
		logic [`ASR_EVT_W-1:0] evt;
		logic [`ASR_EVT_W-1:0] evt_ena;
		asr_state_t state;
		logic [3:0] cnt;
		logic [8:0] rx_shift;
		logic ovr;
		asr_entry_t [DEPTH-1:0] mem;
		logic [PW-1:0] rd_ptr;
		logic [PW-1:0] wr_ptr;
		logic [CW-1:0] count;
	} asr_regs_t;

	asr_regs_t state_reg;
	asr_regs_t state_next;
	logic halt;
	logic bit_stb;
	logic bit_val;

	function automatic logic [PW-1:0] ptr_inc(input logic [PW-1:0] p);
		ptr_inc = (p == LAST_PTR) ? '0 : p + PW'(1);
	endfunction

	// Every field spelt out so each register's reset value is plain to see
	function automatic asr_regs_t regs_at_reset();
		asr_regs_t r;
		r.wait_r = 1'b1;
		r.rdata = 32'h0000_0000;
		r.pop_ok = 1'b0;
		r.irq = 1'b0;
		r.rx_en = 1'(`ASR_CTRL_RST >> `ASR_CTRL_RX_EN);
		r.nine = 1'(`ASR_CTRL_RST >> `ASR_CTRL_NINE);
		r.div = DIV_RST;
		r.evt = '0;
		r.evt_ena = `ASR_EVT_ENA_RST;
		r.state = ASR_IDLE;
		r.cnt = 4'h0;
		r.rx_shift = 9'h000;
		r.ovr = 1'b0;
		r.mem = '0;
		r.rd_ptr = '0;
		r.wr_ptr = '0;
		r.count = '0;
		return r;
	endfunction

	// Framing status and ninth bit ride with the data in each entry
	function automatic asr_entry_t assemble(input logic [8:0] sh, input logic nine,
		input logic stop_bit);
		asr_entry_t e;
		e.frame_err = !stop_bit;
		e.ninth = nine ? sh[8] : 1'b0;
		e.data = nine ? sh[7:0] : sh[8:1];
		return e;
	endfunction

	function automatic logic [31:0] status_word(input asr_entry_t h, input logic ovr,
		input logic ready);
		logic [31:0] w;
		w = 32'h0000_0000;
		w[`ASR_STS_NINTH] = h.ninth;
		w[`ASR_STS_OVR] = ovr;
		w[`ASR_STS_FRAME_ERR] = h.frame_err;
		w[`ASR_STS_READY] = ready;
		return w;
	endfunction

	// Read mux; unmapped and write-only offsets read as zero
	function automatic logic [31:0] read_word(input logic [4:0] a, input asr_regs_t r,
		input asr_entry_t h);
		logic [31:0] w;
		w = 32'h0000_0000;
		case (a)
			`ASR_OFS_CTRL: begin
				w[`ASR_CTRL_RX_EN] = r.rx_en;
				w[`ASR_CTRL_NINE] = r.nine;
			end
			`ASR_OFS_STATUS: w = status_word(h, r.ovr, r.count != '0);
			`ASR_OFS_DATA: w[7:0] = h.data;
			`ASR_OFS_DIV: w[15:0] = r.div;
			`ASR_OFS_EVT: w[`ASR_EVT_W-1:0] = r.evt;
			`ASR_OFS_EVT_ENA: w[`ASR_EVT_W-1:0] = r.evt_ena;
			default: w = 32'h0000_0000;
		endcase
		return w;
	endfunction

	// Register writes; lanes without their byte enable are left alone
	function automatic asr_regs_t apply_write(input asr_regs_t r, input logic [4:0] a,
		input logic [3:0] be, input logic [31:0] d);
		asr_regs_t n;
		n = r;
		case (a)
			`ASR_OFS_CTRL: begin
				if (be[0]) begin
					n.rx_en = d[`ASR_CTRL_RX_EN];
					n.nine = d[`ASR_CTRL_NINE];
				end
			end
			`ASR_OFS_DIV: begin
				if (be[0])
					n.div[7:0] = d[7:0];
				if (be[1])
					n.div[15:8] = d[15:8];
			end
			`ASR_OFS_EVT_CLR: begin
				if (be[0])
					n.evt = r.evt & ~d[`ASR_EVT_W-1:0];
			end
			`ASR_OFS_EVT_ENA: begin
				if (be[0])
					n.evt_ena = d[`ASR_EVT_W-1:0];
			end
			default: begin
			end
		endcase
		return n;
	endfunction

	// Pin taken as synchronous; a metastability guard is the user's job
	asr_front u_front (
		.i_mclk(i_mclk),
		.i_rst_n(i_rst_n),
		.i_enable(state_reg.rx_en),
		.i_halt(halt),
		.i_div(state_reg.div),
		.i_rx(i_serial_receive_pin),
		.o_bit_stb(bit_stb),
		.o_bit(bit_val)
	);

	always_comb begin
		asr_entry_t head;
		asr_entry_t word;
		logic accept;
		logic done;
		logic push;
		logic pop;
		logic [3:0] last_cnt;
		state_next = state_reg;
		head = (state_reg.count != '0) ? state_reg.mem[state_reg.rd_ptr] : '0;
		word = '0;
		push = 1'b0;
		pop = 1'b0;
		halt = 1'b0;
		last_cnt = state_reg.nine ? 4'h8 : 4'h7;
		accept = (i_read || i_write) && state_reg.wait_r;
		done = (i_read || i_write) && !state_reg.wait_r;

		// Bus: one wait cycle, answer in the next; read data is captured at accept, writes act at the answer
		state_next.wait_r = 1'b1;
		state_next.pop_ok = 1'b0;
		if (accept) begin
			state_next.wait_r = 1'b0;
			if (i_read) begin
				state_next.rdata = read_word(i_address, state_reg, head);
				// Pop only what was shown, not a word pushed meanwhile
				state_next.pop_ok = (i_address == `ASR_OFS_DATA) && (state_reg.count != '0);
			end
		end

		if (done && i_read && state_reg.pop_ok)
			pop = 1'b1;

		// A new divisor acts at once, so change it only while the line is idle
		if (done && i_write)
			state_next = apply_write(state_next, i_address, i_byteenable, i_writedata);

		// Dropping the enable resets the receive logic, the only way out of overrun
		if (!state_reg.rx_en) begin
			state_next.state = ASR_IDLE;
			state_next.ovr = 1'b0;
			halt = 1'b1;
		end else if (bit_stb) begin
			case (state_reg.state)
				ASR_IDLE: begin
					// First strobe is the start bit; a high vote was a glitch
					if (!bit_val) begin
						state_next.state = ASR_DATA;
						state_next.cnt = 4'h0;
					end else begin
						halt = 1'b1;
					end
				end
				ASR_DATA: begin
					state_next.rx_shift = {bit_val, state_reg.rx_shift[8:1]};
					state_next.cnt = state_reg.cnt + 4'h1;
					if (state_reg.cnt == last_cnt)
						state_next.state = ASR_STOP;
				end
				ASR_STOP: begin
					// Stop bit judged at mid-bit, so the next start edge is not missed
					halt = 1'b1;
					state_next.state = ASR_IDLE;
					word = assemble(state_reg.rx_shift, state_reg.nine, bit_val);
					if (state_reg.ovr) begin
						word = '0;
					end else if (state_reg.count == FULL_CNT && !pop) begin
						state_next.ovr = 1'b1;
						state_next.evt[`ASR_EVT_OVR] = 1'b1;
					end else begin
						push = 1'b1;
						state_next.evt[`ASR_EVT_WORD] = 1'b1;
						if (!bit_val)
							state_next.evt[`ASR_EVT_FRAME_ERR] = 1'b1;
					end
				end
				default: begin
					state_next.state = ASR_IDLE;
					halt = 1'b1;
				end
			endcase
		end

		// Two-entry store lets two words wait while a third shifts in
		if (push) begin
			state_next.mem[state_reg.wr_ptr] = word;
			state_next.wr_ptr = ptr_inc(state_reg.wr_ptr);
		end
		if (pop)
			state_next.rd_ptr = ptr_inc(state_reg.rd_ptr);
		if (push && !pop)
			state_next.count = state_reg.count + CW'(1);
		else if (pop && !push)
			state_next.count = state_reg.count - CW'(1);

		state_next.irq = |(state_next.evt & state_next.evt_ena);
	end

	always_ff @(posedge i_mclk) begin
		if (!i_rst_n) begin
			state_reg <= regs_at_reset();
		end else begin
			state_reg <= state_next;
		end
	end

	assign o_readdata = state_reg.rdata;
	assign o_waitrequest = state_reg.wait_r;
	assign o_irq = state_reg.irq;

endmodule

// [test/asr_receiver_checker.sv]
`timescale 1ns/1ps
`include "asr_map.svh"

module asr_receiver_checker (
	input wire logic i_mclk, // System clock
	input wire logic i_rst_n, // Reset, active low
	input wire logic [4:0] i_address, // Bus address
	input wire logic i_read, // Bus read
	input wire logic i_write, // Bus write
	input wire logic [31:0] o_readdata, // Bus read data
	input wire logic o_waitrequest, // Bus wait
	input wire logic o_irq // Interrupt
);
	default clocking @(posedge i_mclk); endclocking
	default disable iff (!i_rst_n);

	property p_ack_one;
		!o_waitrequest |=> o_waitrequest;
	endproperty
	a_ack_one: assert property (p_ack_one) else $error("ack held too long");
	property p_ack_due;
		o_waitrequest && (i_read || i_write) |=> !o_waitrequest;
	endproperty
	a_ack_due: assert property (p_ack_due) else $error("ack late");
	property p_ack_cause;
		!o_waitrequest |-> $past(i_read) || $past(i_write);
	endproperty
	a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
	property p_rd_hold;
		o_waitrequest |-> $stable(o_readdata);
	endproperty
	a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
	property p_head_empty;
		!o_waitrequest && i_read && i_address == `ASR_OFS_STATUS
			&& !o_readdata[`ASR_STS_READY] |-> o_readdata[`ASR_STS_FRAME_ERR] == 1'b0
			&& o_readdata[`ASR_STS_NINTH] == 1'b0;
	endproperty
	a_head_empty: assert property (p_head_empty) else $error("head bits without word");
	property p_data_width;
		!o_waitrequest && i_read && i_address == `ASR_OFS_DATA |-> o_readdata[31:8] == 24'h0;
	endproperty
	a_data_width: assert property (p_data_width) else $error("data upper bits set");
	property p_unmapped;
		!o_waitrequest && i_read && i_address > `ASR_OFS_EVT_ENA |-> o_readdata == 32'h0;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
	property p_irq_fall;
		$fell(o_irq) |-> $past(i_write) || $past(i_write, 2);
	endproperty
	a_irq_fall: assert property (p_irq_fall) else $error("irq dropped alone");
endmodule

bind asr_receiver asr_receiver_checker u_chk (.i_mclk(i_mclk), .i_rst_n(i_rst_n),
	.i_address(i_address), .i_read(i_read), .i_write(i_write), .o_readdata(o_readdata),
	.o_waitrequest(o_waitrequest), .o_irq(o_irq));

// [test/asr_serial_tx.sv]
`timescale 1ns/1ps

module asr_serial_tx #(
	parameter int BIT_CLKS = 64 // Clocks per bit
) (
	input wire logic i_mclk, // System clock
	output logic o_line // Serial line, idle high
);
	initial o_line = 1'b1;

	// Stop level is chosen by the caller so framing faults can be forced
	task automatic send(input logic [8:0] w, input logic nine, input logic stop);
		logic [10:0] f;
		f = nine ? {stop, w, 1'b0} : {1'b1, stop, w[7:0], 1'b0};
		for (int i = 0; i < (nine ? 11 : 10); i++) begin
			o_line <= f[i];
			repeat (BIT_CLKS) @(posedge i_mclk);
		end
		o_line <= 1'b1;
		repeat (BIT_CLKS) @(posedge i_mclk);
	endtask
endmodule

// [test/asr_receiver_tb.sv]
`timescale 1ns/1ps
`include "asr_map.svh"
`define CHK(got, exp) begin n_tests++; if ((got) !== (exp)) begin miscompares++; \
	$display("[ERR] %0t got %h exp %h", $time, got, exp); end end

module asr_receiver_tb;
	localparam int DIV = 4;
	logic i_mclk;
	logic i_rst_n;
	logic i_read;
	logic i_write;
	logic [4:0] i_address;
	logic [31:0] i_writedata;
	logic [31:0] o_readdata;
	logic [31:0] rd_val;
	logic o_waitrequest;
	logic o_irq;
	logic rx_line;
	int miscompares = 0;
	int n_tests = 0;
	int cycles = 0;

	asr_receiver dut (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_address(i_address),
		.i_read(i_read), .i_write(i_write), .i_byteenable(4'hf), .i_writedata(i_writedata),
		.o_readdata(o_readdata), .o_waitrequest(o_waitrequest),
		.i_serial_receive_pin(rx_line), .o_irq(o_irq));
	asr_serial_tx #(.BIT_CLKS(16 * DIV)) tx (.i_mclk(i_mclk), .o_line(rx_line));

	initial begin
		i_mclk = 1'b0;
		forever #4 i_mclk = ~i_mclk;
	end

	task automatic finish_test();
		$display("miscompares %0d n_tests %0d", miscompares, n_tests);
		if (miscompares == 0 && n_tests > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	// Hang guard, well above the seven frames sent
	always @(posedge i_mclk) begin
		cycles++;
		if (cycles == 40000) begin
			miscompares++;
			finish_test();
		end
	end

	task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
		@(posedge i_mclk);
		i_read <= !wr;
		i_write <= wr;
		i_address <= a;
		i_writedata <= d;
		do @(posedge i_mclk); while (o_waitrequest !== 1'b0);
		rd_val = o_readdata;
		i_read <= 1'b0;
		i_write <= 1'b0;
	endtask

	task automatic rd_chk(input logic [4:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		`CHK(rd_val, e)
	endtask

	task automatic irq_chk(input logic e);
		repeat (2) @(posedge i_mclk);
		`CHK(o_irq, e)
	endtask

	initial begin
		i_rst_n = 1'b0;
		i_read = 1'b0;
		i_write = 1'b0;
		i_address = 5'h00;
		i_writedata = 32'h0;
		repeat (3) @(posedge i_mclk);
		i_rst_n <= 1'b1;
		rd_chk(`ASR_OFS_CTRL, 32'h0);
		rd_chk(`ASR_OFS_DIV, 32'h43);
		rd_chk(`ASR_OFS_EVT_ENA, 32'h0);
		rd_chk(`ASR_OFS_STATUS, 32'h0);
		rd_chk(`ASR_OFS_DATA, 32'h0);
		rd_chk(5'h1c, 32'h0);
		bus(1'b1, `ASR_OFS_DIV, DIV);
		rd_chk(`ASR_OFS_DIV, DIV);
		tx.send(9'h0a5, 1'b0, 1'b1);
		rd_chk(`ASR_OFS_STATUS, 32'h0);
		bus(1'b1, `ASR_OFS_EVT_ENA, 32'h1);
		bus(1'b1, `ASR_OFS_CTRL, 32'h1);
		tx.send(9'h0a5, 1'b0, 1'b1);
		irq_chk(1'b1);
		rd_chk(`ASR_OFS_STATUS, 32'h8);
		rd_chk(`ASR_OFS_EVT, 32'h1);
		rd_chk(`ASR_OFS_DATA, 32'ha5);
		rd_chk(`ASR_OFS_STATUS, 32'h0);
		bus(1'b1, `ASR_OFS_EVT_CLR, 32'h7);
		irq_chk(1'b0);
		bus(1'b1, `ASR_OFS_EVT_ENA, 32'h0);
		tx.send(9'h03c, 1'b0, 1'b0);
		tx.send(9'h081, 1'b0, 1'b1);
		tx.send(9'h055, 1'b0, 1'b1);
		irq_chk(1'b0);
		rd_chk(`ASR_OFS_EVT, 32'h7);
		rd_chk(`ASR_OFS_STATUS, 32'he);
		rd_chk(`ASR_OFS_DATA, 32'h3c);
		rd_chk(`ASR_OFS_STATUS, 32'ha);
		rd_chk(`ASR_OFS_DATA, 32'h81);
		tx.send(9'h011, 1'b0, 1'b1);
		rd_chk(`ASR_OFS_STATUS, 32'h2);
		rd_chk(`ASR_OFS_DATA, 32'h0);
		bus(1'b1, `ASR_OFS_CTRL, 32'h0);
		bus(1'b1, `ASR_OFS_CTRL, 32'h1);
		rd_chk(`ASR_OFS_STATUS, 32'h0);
		bus(1'b1, `ASR_OFS_CTRL, 32'h3);
		tx.send(9'h1a5, 1'b1, 1'b1);
		rd_chk(`ASR_OFS_STATUS, 32'h9);
		rd_chk(`ASR_OFS_DATA, 32'ha5);
		finish_test();
	end
endmodule
